// file: sim/vsg_sync_pulse_gen_test.sv
`timescale 1ns/10ps
module vsg_sync_pulse_gen_test
	import vsg_pkg::*;
;
	logic              clock, rst, wr, rd, evr, lps, rd_q, av_q, nf_q;
	logic [ADDR_W-1:0] addr;
	logic [7:0]        wdata, rdata, stb, msk;
	logic [2:0]        ev;
	logic [3:0]        hs, vs;
	logic              burst_sample, active_video, new_field, line_offset, mixed_sync_in;
	logic [1:0]        proc_mode, pm;
	logic [15:0]       rnd;
	int                n_fail, n_checks, cyc, t0, i;
	logic [7:0]        rq[$];
	int                tq[$];

	vsg_sync_source src (.clock(clock), .hs(hs), .vs(vs));
	vsg_sync_pulse_gen uut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .ext_hsync(hs[0]), .ext_vsync(vs[0]), .dig_hsync(hs[1]),
		.dig_vsync(vs[1]), .d1_hsync(hs[2]), .d1_vsync(vs[2]), .d2_hsync(hs[3]),
		.d2_vsync(vs[3]), .field_edge(ev[0]), .last_vertical_pulse(ev[1]),
		.vblank_end(ev[2]), .external_video_reference(evr), .lowpass_sync(lps),
		.burst_sample(burst_sample), .active_video(active_video), .new_field(new_field),
		.line_offset(line_offset), .mixed_sync_in(mixed_sync_in), .proc_mode(proc_mode));

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// every bus task sets both strobes and all but idle last one cycle, so no signal is assigned twice
	task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
		addr <= {idx, 2'b00};
		wdata <= d;
		wr <= 1'b1;
		rd <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rreg(input logic [7:0] idx, input logic [7:0] e);
		rq.push_back(e);
		addr <= {idx, 2'b01};
		wr <= 1'b0;
		rd <= 1'b1;
		@(posedge clock);
	endtask
	task automatic idle(input int n);
		wr <= 1'b0;
		rd <= 1'b0;
		repeat (n) @(posedge clock);
	endtask
	task automatic pulse(input int b);
		wr <= 1'b0;
		rd <= 1'b0;
		ev[b] <= 1'b1;
		@(posedge clock);
		ev <= 3'h0;
	endtask

	// one line shape; a foreign hsync first must start nothing; p > 0 lets the line repeat
	task automatic shape(input logic [1:0] s, input logic [7:0] st, bt, input logic [9:0] av,
		input int p, input logic o);
		wreg(IDX_SYNC_SOURCE, {4'h0, s, 1'b0, o});
		wreg(IDX_SYNC_TO_BURST, st);
		wreg(IDX_BURST_TO_ACTIVE, bt);
		wreg(IDX_ACTIVE_LOW, av[7:0]);
		wreg(IDX_LINE_PERIOD_LOW, 8'(p));
		wreg(IDX_ACTIVE_PERIOD_HI, {2'b00, av[9:8], 1'b0, 3'(p >> 8)});
		idle(0); // drop the strobe so the last write is not repeated
		src.line(s + 2'h1, 1);
		idle(2);
		t0 = cyc + 1 + st + 3;
		for (int k = 0; k < ((p > 0) ? 2 : 1); k++) begin
			tq.push_back(t0 + k * p);
			tq.push_back(t0 + k * p + bt + 1);
			tq.push_back(t0 + k * p + bt + 1 + av);
		end
		src.line(s, 1 + s[0]);
		idle(t0 + p + bt + av + 8 - cyc);
		wreg(IDX_LINE_PERIOD_LOW, 8'h00);
		idle(1);
	endtask

	// results appear here and are matched to the oldest note
	always @(posedge clock) begin
		cyc <= cyc + 1;
		rd_q <= rd;
		av_q <= active_video;
		nf_q <= new_field;
		if (!rst && rd_q)
			check(rdata, rq.pop_front(), "read data");
		if (!rst && (burst_sample || active_video !== av_q || (new_field && !nf_q))) begin
			if (tq.size() == 0)
				check(8'h01, 8'h00, "unexpected timing event");
			else
				check(8'(cyc - tq.pop_front()), 8'h00, "timing event offset");
		end
	end

	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// watchdog: the whole sequence needs under a thousand cycles
	initial begin
		#(20000 * 50);
		n_fail++;
		final_report();
	end

	initial begin
		{rst, wr, rd, addr, wdata, ev, evr, lps, rd_q, av_q, nf_q} = '0;
		rst = 1'b1;
		{cyc, n_fail, n_checks} = '0;
		rnd = 16'd11999;
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		// reset values, then all ones to see which bits hold
		for (i = 8'h10; i < 8'h17; i++)
			rreg(8'(i), RST_REG);
		for (i = 8'h10; i < 8'h17; i++)
			wreg(8'(i), 8'hff);
		wreg(8'h20, 8'hff);
		for (i = 8'h10; i < 8'h17; i++) begin
			msk = (i == 8'h14) ? 8'h37 : (i == 8'h15) ? 8'h7f : (i == 8'h16) ? 8'h3f : 8'hff;
			rreg(8'(i), msk);
		end
		rreg(8'h20, 8'h00);
		idle(1);
		// every sync source, random counts
		for (i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			stb = (i == 1) ? 8'(25 + rnd[4:0]) - 8'd25 : {3'h0, rnd[4:0]};
			shape(2'(i), stb, {4'h0, rnd[8:5]}, {6'h0, rnd[12:9]} + 10'h1, 0, 1'b0);
		end
		shape(2'h0, 8'h03, 8'h02, 10'h103, 0, 1'b0);
		shape(2'h0, 8'h02, 8'h01, 10'h004, 60, 1'b0);
		// window actions for both bits, full window and empty window
		for (i = 0; i < 6; i++) begin
			wreg(IDX_VWIN_CONTROL, {1'b0, (i < 4) ? 5'h1f : 5'h00, 2'(i)});
			pulse(1);
			idle(3);
			pm = (i < 4) ? (i[1] ? PROC_RAW : PROC_SIMPLE) : (i[0] ? PROC_SIMPLE : PROC_BLANK);
			@(negedge clock);
			check({6'h0, proc_mode}, {6'h0, pm}, "window mode");
			@(posedge clock);
			pulse(2);
			idle(3);
			@(negedge clock);
			check({6'h0, proc_mode}, {6'h0, PROC_NORMAL}, "after blanking");
			@(posedge clock);
		end
		// new-field delay for every code
		for (i = 0; i < 4; i++) begin
			wreg(IDX_SYNC_SOURCE, {2'b00, 2'(i), 4'h0});
			idle(1);
			tq.push_back(cyc + 1 + i);
			pulse(0);
			idle(6);
		end
		// mixed sync separator follows the selected candidate
		for (i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			wreg(IDX_SYNC_SOURCE, {6'h00, i[0], 1'b0});
			idle(0);
			evr <= rnd[0];
			lps <= rnd[1];
			@(negedge clock);
			check({7'h0, mixed_sync_in}, {7'h0, i[0] ? rnd[0] : rnd[1]}, "mixed sync");
			@(posedge clock);
		end
		// line offset alternates per line after a field when enabled
		wreg(IDX_SYNC_SOURCE, 8'h01);
		idle(0);
		src.field(2'h0);
		idle(1);
		for (i = 0; i < 3; i++) begin
			@(negedge clock);
			check({7'h0, line_offset}, {7'h0, i[0]}, "line offset");
			@(posedge clock);
			shape(2'h0, 8'h02, 8'h01, 10'h004, 0, i < 2);
		end
		@(negedge clock);
		check({7'h0, line_offset}, 8'h00, "offset disabled");
		@(posedge clock);
		final_report();
	end
endmodule

// file: sim/vsg_sync_source.sv
`timescale 1ns/10ps
// far-side sync source: one hsync/vsync pair per source select code
module vsg_sync_source (
	// clock
	input  wire logic       clock,
	// sync lines, bit index = source select code
	output logic      [3:0] hs,
	output logic      [3:0] vs
);
	// lines idle low between pulses, as a real source does
	initial begin
		hs = 4'h0;
		vs = 4'h0;
	end
	// hsync held w cycles; a wide pulse models a slow source
	task automatic line(input logic [1:0] s, input int w);
		@(posedge clock);
		hs[s] <= 1'b1;
		repeat (w) @(posedge clock);
		hs[s] <= 1'b0;
	endtask
	// one-cycle vsync marks a new field
	task automatic field(input logic [1:0] s);
		@(posedge clock);
		vs[s] <= 1'b1;
		@(posedge clock);
		vs[s] <= 1'b0;
	endtask
endmodule

// file: src/vsg_pkg.sv
package vsg_pkg;
	// register indices (byte address = 4 * index)
	localparam logic [7:0] IDX_LINE_PERIOD_LOW   = 8'h10;
	localparam logic [7:0] IDX_SYNC_TO_BURST     = 8'h11;
	localparam logic [7:0] IDX_BURST_TO_ACTIVE   = 8'h12;
	localparam logic [7:0] IDX_ACTIVE_LOW        = 8'h13;
	localparam logic [7:0] IDX_ACTIVE_PERIOD_HI  = 8'h14;
	localparam logic [7:0] IDX_VWIN_CONTROL      = 8'h15;
	localparam logic [7:0] IDX_SYNC_SOURCE       = 8'h16;
	localparam logic [7:0] IDX_STATUS            = 8'h17;
	localparam int         ADDR_W                = 10;
	// writable bit masks; reserved bits are dropped on write
	localparam logic [7:0] MASK_ACTIVE_PERIOD_HI = 8'h37;
	localparam logic [7:0] MASK_VWIN_CONTROL     = 8'h7f;
	localparam logic [7:0] MASK_SYNC_SOURCE      = 8'h3f;
	// field positions
	localparam int POS_ACTIVE_HI   = 4;
	localparam int POS_PERIOD_HI   = 0;
	localparam int POS_VWIN_LINES  = 2;
	localparam int POS_INSIDE_ACT  = 1;
	localparam int POS_OUTSIDE_ACT = 0;
	localparam int POS_FRAME_DLY   = 4;
	localparam int POS_SRC_SEL     = 2;
	localparam int POS_MIXED_SRC   = 1;
	localparam int POS_LINE_OFS    = 0;
	// reset values
	localparam logic [7:0] RST_REG = 8'h00;
	// sync source encodings
	localparam logic [1:0] SRC_EXTERNAL  = 2'h0;
	localparam logic [1:0] SRC_DIGITIZED = 2'h1;
	localparam logic [1:0] SRC_EMBED_D1  = 2'h2;
	localparam logic [1:0] SRC_EMBED_D2  = 2'h3;
	// processing modes on the data path
	localparam logic [1:0] PROC_NORMAL = 2'h0;
	localparam logic [1:0] PROC_SIMPLE = 2'h1;
	localparam logic [1:0] PROC_RAW    = 2'h2;
	localparam logic [1:0] PROC_BLANK  = 2'h3;
	// line phase states
	typedef enum logic [3:0] {
		VSG_TO_BURST  = 4'b0001,
		VSG_TO_ACTIVE = 4'b0010,
		VSG_ACTIVE    = 4'b0100,
		VSG_TAIL      = 4'b1000
	} vsg_phase_e;
endpackage

// file: src/vsg_sync_pulse_gen.sv
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
// Overview of operation
// - count sync-to-burst pixels from sync, then pulse burst sample-and-hold
// - count burst-to-active pixels from burst point, then start active video
// - active-line pixel count is 10 bits: low register plus bits 5-4 above
// - line period is 11 bits; top three bits in bits 2-0 of shared register
// - line period low eight bits come from the first register, index 0x10
// - bits 6-2 give 0 to 31 window lines after the last vertical pulse
// - inside window: low means simple decoder, high means raw luma, zero chroma
// - after window until blanking end: low blanks YUV, high uses simple decoder
// - bits 5-4 delay the new-field detect by 0 to 3 pixels
// - bits 3-2 pick sync input: external, digitized, D1 or D2 timing words
// - mixed sync separator uses external reference when bit 1 high, else filter
// - bit 0 high gives the sync state machine a one-line offset
module vsg_sync_pulse_gen
	import vsg_pkg::*;
#(
	parameter int ACT_W = 10,
	parameter int PER_W = 11
) (
	// clock and reset
	input  wire logic              clock,
	input  wire logic              rst,
	// register port
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [7:0]        wdata,
	input  wire logic              wr,
	input  wire logic              rd,
	output logic      [7:0]        rdata,
	// sync sources, same clock domain as the pixel clock
	input  wire logic              ext_hsync,
	input  wire logic              ext_vsync,
	input  wire logic              dig_hsync,
	input  wire logic              dig_vsync,
	input  wire logic              d1_hsync,
	input  wire logic              d1_vsync,
	input  wire logic              d2_hsync,
	input  wire logic              d2_vsync,
	input  wire logic              field_edge,
	input  wire logic              last_vertical_pulse,
	input  wire logic              vblank_end,
	// mixed sync separator inputs
	input  wire logic              external_video_reference,
	input  wire logic              lowpass_sync,
	// timing outputs
	output logic                   burst_sample,
	output logic                   active_video,
	output logic                   new_field,
	output logic                   line_offset,
	output logic                   mixed_sync_in,
	output logic [1:0]             proc_mode
);

	logic [7:0]       line_period_low;
	logic [7:0]       sync_to_burst_delay;
	logic [7:0]       burst_to_active_delay;
	logic [7:0]       active_pixels_low;
	logic [7:0]       active_and_line_period_high;
	logic [7:0]       vertical_window_control;
	logic [7:0]       sync_source_config;
	logic [ACT_W-1:0] active_line_pixels;
	logic [PER_W-1:0] line_period_pixels;
	logic [4:0]       vertical_window_lines;
	logic             window_inside_action;
	logic             window_outside_action;
	logic [1:0]       frame_detect_delay;
	logic [1:0]       sync_source_select;
	logic             mixed_sync_source;
	logic             state_machine_line_offset;
	logic             hsync_sel;
	logic             vsync_sel;
	logic             hsync_prev;
	logic             hsync_start;
	vsg_phase_e       phase;
	logic [7:0]       seg_cnt;
	logic [ACT_W-1:0] act_cnt;
	logic [PER_W-1:0] pix_cnt;
	logic [2:0]       field_dly;
	logic [4:0]       win_cnt;
	logic             in_window;
	logic             in_vblank;
	logic             odd_line;

	// word index from byte address
	function automatic logic [7:0] word_idx(input logic [ADDR_W-1:0] a);
		word_idx = a[ADDR_W-1:2];
	endfunction

	// register writes; reserved bits masked off so they always read zero
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			line_period_low             <= RST_REG;
			sync_to_burst_delay         <= RST_REG;
			burst_to_active_delay       <= RST_REG;
			active_pixels_low           <= RST_REG;
			active_and_line_period_high <= RST_REG;
			vertical_window_control     <= RST_REG;
			sync_source_config          <= RST_REG;
		end else if (wr && addr[1:0] == 2'h0) begin
			case (word_idx(addr))
				IDX_LINE_PERIOD_LOW:  line_period_low <= wdata;
				IDX_SYNC_TO_BURST:    sync_to_burst_delay <= wdata;
				IDX_BURST_TO_ACTIVE:  burst_to_active_delay <= wdata;
				IDX_ACTIVE_LOW:       active_pixels_low <= wdata;
				IDX_ACTIVE_PERIOD_HI: active_and_line_period_high <= wdata & MASK_ACTIVE_PERIOD_HI;
				IDX_VWIN_CONTROL:     vertical_window_control <= wdata & MASK_VWIN_CONTROL;
				IDX_SYNC_SOURCE:      sync_source_config <= wdata & MASK_SYNC_SOURCE;
				default: ;
			endcase
		end
	end

	// field extraction
	assign active_line_pixels = {active_and_line_period_high[POS_ACTIVE_HI +: 2],
		active_pixels_low};
	assign line_period_pixels = {active_and_line_period_high[POS_PERIOD_HI +: 3],
		line_period_low};
	assign vertical_window_lines     = vertical_window_control[POS_VWIN_LINES +: 5];
	assign window_inside_action      = vertical_window_control[POS_INSIDE_ACT];
	assign window_outside_action     = vertical_window_control[POS_OUTSIDE_ACT];
	assign frame_detect_delay        = sync_source_config[POS_FRAME_DLY +: 2];
	assign sync_source_select        = sync_source_config[POS_SRC_SEL +: 2];
	assign mixed_sync_source         = sync_source_config[POS_MIXED_SRC];
	assign state_machine_line_offset = sync_source_config[POS_LINE_OFS];

	// sync input multiplexer
	always_comb begin
		case (sync_source_select)
			SRC_EXTERNAL: begin
				hsync_sel = ext_hsync;
				vsync_sel = ext_vsync;
			end
			SRC_DIGITIZED: begin
				hsync_sel = dig_hsync;
				vsync_sel = dig_vsync;
			end
			SRC_EMBED_D1: begin
				hsync_sel = d1_hsync;
				vsync_sel = d1_vsync;
			end
			default: begin
				hsync_sel = d2_hsync;
				vsync_sel = d2_vsync;
			end
		endcase
	end

	// mixed sync separator source
	assign mixed_sync_in = mixed_sync_source ? external_video_reference : lowpass_sync;

	// sync edge: selected source or free-running period wrap
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			hsync_prev <= 1'b0;
		else
			hsync_prev <= hsync_sel;
	end
	// a period of zero disables the flywheel so only real syncs restart the line
	assign hsync_start = (hsync_sel && !hsync_prev) ||
		(line_period_pixels != '0 && pix_cnt == line_period_pixels - PER_W'(1));

	// pixel counter across the whole line
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			pix_cnt <= '0;
		else if (hsync_start)
			pix_cnt <= '0;
		else
			pix_cnt <= pix_cnt + PER_W'(1);
	end

	// line phase machine: sync, burst, active, tail
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			phase        <= VSG_TAIL;
			seg_cnt      <= '0;
			act_cnt      <= '0;
			burst_sample <= 1'b0;
			active_video <= 1'b0;
		end else begin
			burst_sample <= 1'b0;
			if (hsync_start) begin
				phase        <= VSG_TO_BURST;
				seg_cnt      <= '0;
				active_video <= 1'b0;
			end else begin
				case (phase)
					VSG_TO_BURST: begin
						if (seg_cnt == sync_to_burst_delay) begin
							burst_sample <= 1'b1;
							phase        <= VSG_TO_ACTIVE;
							seg_cnt      <= '0;
						end else
							seg_cnt <= seg_cnt + 8'h01;
					end
					VSG_TO_ACTIVE: begin
						if (seg_cnt == burst_to_active_delay) begin
							phase        <= (active_line_pixels == '0) ? VSG_TAIL : VSG_ACTIVE;
							active_video <= (active_line_pixels != '0);
							act_cnt      <= '0;
						end else
							seg_cnt <= seg_cnt + 8'h01;
					end
					VSG_ACTIVE: begin
						if (act_cnt == active_line_pixels - ACT_W'(1)) begin
							phase        <= VSG_TAIL;
							active_video <= 1'b0;
						end else
							act_cnt <= act_cnt + ACT_W'(1);
					end
					VSG_TAIL: ;
					default: phase <= VSG_TAIL;
				endcase
			end
		end
	end

	// new field detect, delayed 0 to 3 pixels through a shift line
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			field_dly <= '0;
		else
			field_dly <= {field_dly[1:0], field_edge};
	end
	assign new_field = (frame_detect_delay == 2'h0) ? field_edge
		: field_dly[frame_detect_delay - 2'h1];

	// line parity for the state machine offset
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			odd_line <= 1'b0;
		else if (vsync_sel)
			odd_line <= 1'b0;
		else if (hsync_start)
			odd_line <= ~odd_line;
	end
	assign line_offset = state_machine_line_offset & odd_line;

	// vertical window line counter after the last vertical pulse
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			win_cnt   <= '0;
			in_window <= 1'b0;
			in_vblank <= 1'b0;
		end else if (last_vertical_pulse) begin
			win_cnt   <= '0;
			in_window <= (vertical_window_lines != '0);
			in_vblank <= 1'b1;
		end else begin
			if (vblank_end) begin
				in_vblank <= 1'b0;
				in_window <= 1'b0;
			end else if (hsync_start && in_window) begin
				if (win_cnt == vertical_window_lines - 5'h01)
					in_window <= 1'b0;
				win_cnt <= win_cnt + 5'h01;
			end
		end
	end

	// processing mode select
	always_comb begin
		if (in_window)
			proc_mode = window_inside_action ? PROC_RAW : PROC_SIMPLE;
		else if (in_vblank)
			proc_mode = window_outside_action ? PROC_SIMPLE : PROC_BLANK;
		else
			proc_mode = PROC_NORMAL;
	end

	// read data one cycle after the strobe
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			rdata <= 8'h00;
		else if (rd) begin
			case (word_idx(addr))
				IDX_LINE_PERIOD_LOW:  rdata <= line_period_low;
				IDX_SYNC_TO_BURST:    rdata <= sync_to_burst_delay;
				IDX_BURST_TO_ACTIVE:  rdata <= burst_to_active_delay;
				IDX_ACTIVE_LOW:       rdata <= active_pixels_low;
				IDX_ACTIVE_PERIOD_HI: rdata <= active_and_line_period_high;
				IDX_VWIN_CONTROL:     rdata <= vertical_window_control;
				IDX_SYNC_SOURCE:      rdata <= sync_source_config;
				IDX_STATUS:           rdata <= {3'h0, odd_line, in_vblank, in_window, active_video,
					burst_sample};
				default:              rdata <= 8'h00;
			endcase
		end else
			rdata <= 8'h00;
	end

	// with zero sync-to-burst delay the burst pulse lands two cycles after the sync start
	AST_BURST_AFTER_SYNC: assert property (@(posedge clock) disable iff (rst)
		(hsync_start && sync_to_burst_delay == 8'h00) ##1 !hsync_start |=> burst_sample)
		else $error("burst pulse missing after zero delay");
	AST_BURST_ONE_CYCLE: assert property (@(posedge clock) disable iff (rst)
		burst_sample |=> !burst_sample)
		else $error("burst pulse longer than one cycle");
	AST_ACTIVE_AFTER_BURST: assert property (@(posedge clock) disable iff (rst)
		(burst_sample && burst_to_active_delay == 8'h00 && active_line_pixels != '0
		&& !hsync_start) |=> active_video)
		else $error("active video late after burst");
	AST_NO_ACTIVE_BEFORE_BURST: assert property (@(posedge clock) disable iff (rst)
		phase == VSG_TO_BURST |-> !active_video)
		else $error("active video before burst point");
	AST_ACTIVE_LEN_ONE: assert property (@(posedge clock) disable iff (rst)
		($rose(active_video) && active_line_pixels == ACT_W'(1) && !hsync_start)
		|=> !active_video)
		else $error("one pixel active line too long");
	AST_PERIOD_WRAP: assert property (@(posedge clock) disable iff (rst)
		(line_period_pixels != '0 && pix_cnt == line_period_pixels - PER_W'(1))
		|=> pix_cnt == '0)
		else $error("line period did not wrap");
	AST_WINDOW_ZERO: assert property (@(posedge clock) disable iff (rst)
		(last_vertical_pulse && vertical_window_lines == 5'h00) |=> !in_window)
		else $error("window open with zero lines");
	AST_WINDOW_CLOSE: assert property (@(posedge clock) disable iff (rst)
		(in_window && hsync_start && !last_vertical_pulse
		&& win_cnt == vertical_window_lines - 5'h01) |=> !in_window)
		else $error("window longer than programmed");
	AST_INSIDE_RAW: assert property (@(posedge clock) disable iff (rst)
		(in_window && window_inside_action) |-> proc_mode == PROC_RAW)
		else $error("inside window mode wrong");
	AST_OUTSIDE_BLANK: assert property (@(posedge clock) disable iff (rst)
		(!in_window && in_vblank && !window_outside_action) |-> proc_mode == PROC_BLANK)
		else $error("outside window not blanked");
	AST_FIELD_DELAY3: assert property (@(posedge clock) disable iff (rst)
		frame_detect_delay == 2'h3 |->
		new_field == $past(field_edge, 3))
		else $error("field detect delay wrong");
	AST_MIXED_SRC: assert property (@(posedge clock) disable iff (rst)
		mixed_sync_in == (mixed_sync_source ? external_video_reference : lowpass_sync))
		else $error("mixed sync source wrong");
	AST_NO_OFFSET: assert property (@(posedge clock) disable iff (rst)
		!state_machine_line_offset |-> !line_offset)
		else $error("line offset without enable");
	AST_RESERVED_ZERO: assert property (@(posedge clock) disable iff (rst)
		(active_and_line_period_high & ~MASK_ACTIVE_PERIOD_HI) == 8'h00)
		else $error("reserved bits stored");

endmodule
